// ==== shared/tfoc_pkg.sv ====
// Package: constants, types and field layout of the temperature format / overtemp config register
// Notes on behaviour
// - Format bit set: temperatures use twos complement range.
// - Format bit clear: temperatures use offset-64 range.
// - A format change immediately changes decoding of all temperature registers.
// - Offset-range bit clear: offsets span -63 to +64 in half-degree steps; the code decodes -64 to +63.5.
// - Offset-range bit set: offsets span -63 to +127 in one-degree steps; the code decodes -128 to +127.
// - Offset-range choice applies to remote-1, local and remote-2 offset registers.
// - Bit 2 makes general pin six an input (0) or output (1).
// - Bit 3 sets pin six output active level: 0 low, 1 high.
// - Bit 4 selects voltage-ID inputs (0) or general I/O (1) on five pins.
// - Bit 5 lets remote-1 overtemp limit drive the overtemp pin.
// - Bit 6 lets local overtemp limit drive the overtemp pin.
// - Bit 7 lets remote-2 overtemp limit drive the overtemp pin.
// - Offset-64 format: limit of -64 degrees disables that channel's overtemp assertion.
// - Twos complement format: limit of -128 degrees disables that channel's assertion.
// - When the lock bit is set, writes to this register are ignored.
// - Power-on value is 0x01: twos complement, everything else clear.
package tfoc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] TFOC_ADDR  = 8'h7c;
    localparam logic [7:0] TFOC_RESET = 8'h01;

    localparam int BIT_TWOS   = 0;
    localparam int BIT_OFSRNG = 1;
    localparam int BIT_P6DIR  = 2;
    localparam int BIT_P6POL  = 3;
    localparam int BIT_VIDSEL = 4;
    localparam int BIT_OT_R1  = 5;
    localparam int BIT_OT_LOC = 6;
    localparam int BIT_OT_R2  = 7;

    // ****************************************
    // Temperature codes
    // ****************************************
    localparam logic [7:0] OFS64_BIAS      = 8'h40; // Offset-64 code of 0 degrees
    localparam logic [7:0] LIM_OFF_OFS64   = 8'h00; // -64 degrees in offset-64
    localparam logic [7:0] LIM_OFF_TWOS    = 8'h80; // -128 degrees in twos complement
    localparam int         NCHAN           = 3;     // remote1, local, remote2

    typedef struct packed {
        logic       remote2_overtemp_enable;
        logic       local_overtemp_enable;
        logic       remote1_overtemp_enable;
        logic       voltage_id_pin_select;
        logic       gp_pin6_polarity;
        logic       gp_pin6_direction;
        logic       offset_range_select;
        logic       twos_complement_select;
    } tfoc_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tfoc_req_t;

endpackage

// ==== core/tfoc_chan.sv ====
// Per-channel temperature decode and overtemp comparison
`timescale 1ns/100ps
`default_nettype none
module tfoc_chan (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       twos,
    input  wire logic       ofs_fine,
    input  wire logic [7:0] raw_temp,
    input  wire logic [7:0] raw_offset,
    input  wire logic [7:0] raw_limit,
    input  wire logic       chan_enable,
    output logic signed [9:0] temp_half,
    output logic            over
);
    import tfoc_pkg::*;

    // Decode codes into signed values combinationally, so a format change acts at once
    // Offset-64 subtracts at nine bits so codes below the bias come out negative
    wire logic signed [8:0] temp_deg  = twos ? {raw_temp[7], raw_temp}
                                             : $signed({1'b0, raw_temp})
                                               - $signed({1'b0, OFS64_BIAS});
    wire logic signed [8:0] lim_deg   = twos ? {raw_limit[7], raw_limit}
                                             : $signed({1'b0, raw_limit})
                                               - $signed({1'b0, OFS64_BIAS});
    // Offset in half degrees: fine mode codes are half degrees, coarse are whole
    wire logic signed [9:0] ofs_half  = ofs_fine ? {{2{raw_offset[7]}}, raw_offset}
                                                 : {raw_offset[7], raw_offset, 1'b0};
    wire logic signed [9:0] next_temp = {temp_deg, 1'b0} + ofs_half;
    // Sentinel limit disables assertion for this channel
    wire logic lim_off = twos ? (raw_limit == LIM_OFF_TWOS)
                              : (raw_limit == LIM_OFF_OFS64);
    // Limit kept signed so negative limits compare correctly
    wire logic signed [9:0] lim_half = {lim_deg, 1'b0};
    wire logic next_over = chan_enable && !lim_off && (next_temp >= lim_half);

    always_ff @(posedge clk) begin
        if (srst) begin
            temp_half <= '0;
            over      <= 1'b0;
        end else begin
            temp_half <= next_temp;
            over      <= next_over;
        end
    end

    chk_sentinel_quiet: assert property (@(posedge clk) disable iff (srst)
        (!$past(twos) && $past(raw_limit) == LIM_OFF_OFS64) |-> !over)
        else $error("overtemp asserted with offset-64 disable limit");
    chk_sentinel_twos: assert property (@(posedge clk) disable iff (srst)
        ($past(twos) && $past(raw_limit) == LIM_OFF_TWOS) |-> !over)
        else $error("overtemp asserted with twos disable limit");
endmodule
`default_nettype wire

// ==== core/tfoc_top.sv ====
// Temperature format / overtemp configuration register and the pin steering it controls
`timescale 1ns/100ps
`default_nettype none
module tfoc_top (
    input  wire logic                CLK,
    input  wire logic                SRST,
    input  wire tfoc_pkg::tfoc_req_t REQ,
    input  wire logic                LOCK,
    output logic [7:0]               RDATA,
    output tfoc_pkg::tfoc_cfg_t      CFG,
    input  wire logic [23:0]         RAW_TEMP,
    input  wire logic [23:0]         RAW_OFFSET,
    input  wire logic [23:0]         RAW_LIMIT,
    output logic [29:0]              TEMP_HALF,
    input  wire logic                PIN6_I,
    input  wire logic                PIN6_VALUE,
    output logic                     PIN6_O,
    output logic                     PIN6_OE,
    output logic                     PIN6_IN,
    input  wire logic [4:0]          VID_PINS_I,
    output logic [4:0]               VID_CODE,
    output logic [4:0]               GPIO_IN,
    input  wire logic                OT_I,
    output logic                     OT_O,
    output logic                     OT_OE,
    output logic                     OT_TIMER_IN
);
    import tfoc_pkg::*;

    // ****************************************
    // Register access
    // ****************************************
    tfoc_cfg_t cfg;
    wire logic hit    = REQ.addr == TFOC_ADDR;
    wire logic wr_ok  = REQ.wr && hit && !LOCK;

    // Configuration register; lock silently drops writes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg <= tfoc_cfg_t'(TFOC_RESET);
        end else if (wr_ok) begin
            cfg <= tfoc_cfg_t'(REQ.wdata);
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= '0;
        end else if (REQ.rd) begin
            RDATA <= hit ? 8'(cfg) : '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CFG <= tfoc_cfg_t'(TFOC_RESET);
        end else begin
            CFG <= cfg;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [6:0] sync1;
    logic [6:0] sync2;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= {OT_I, PIN6_I, VID_PINS_I};
            sync2 <= sync1;
        end
    end
    wire logic [4:0] vid_s  = sync2[4:0];
    wire logic       pin6_s = sync2[5];
    wire logic       ot_s   = sync2[6];

    // ****************************************
    // Channels: remote1, local, remote2 share format and offset range
    // ****************************************
    wire logic [NCHAN-1:0] ch_en = {cfg.remote2_overtemp_enable,
                                    cfg.local_overtemp_enable,
                                    cfg.remote1_overtemp_enable};
    logic [NCHAN-1:0] ch_over;
    logic [29:0]      temp_all;

    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : g_ch
            tfoc_chan u_chan (
                .clk        (CLK),
                .srst       (SRST),
                .twos       (cfg.twos_complement_select),
                .ofs_fine   (!cfg.offset_range_select),
                .raw_temp   (RAW_TEMP[g*8 +: 8]),
                .raw_offset (RAW_OFFSET[g*8 +: 8]),
                .raw_limit  (RAW_LIMIT[g*8 +: 8]),
                .chan_enable(ch_en[g]),
                .temp_half  (temp_all[g*10 +: 10]),
                .over       (ch_over[g])
            );
        end
    endgenerate

    // ****************************************
    // Pin steering
    // ****************************************
    // Active-low overtemp pin; driven only when an enabled channel trips
    wire logic any_over     = |ch_over;
    // General pin six: output only when direction is output, polarity applied
    wire logic p6_drive     = cfg.gp_pin6_direction;
    wire logic p6_level     = cfg.gp_pin6_polarity ? PIN6_VALUE : !PIN6_VALUE;
    wire logic vid_mode     = !cfg.voltage_id_pin_select;

    // Outputs registered so every top output comes from a flip-flop
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TEMP_HALF   <= '0;
            OT_O        <= 1'b0;
            OT_OE       <= 1'b0;
            OT_TIMER_IN <= 1'b0;
            PIN6_O      <= 1'b0;
            PIN6_OE     <= 1'b0;
            PIN6_IN     <= 1'b0;
            VID_CODE    <= '0;
            GPIO_IN     <= '0;
        end else begin
            TEMP_HALF   <= temp_all;
            OT_O        <= 1'b0;
            OT_OE       <= any_over;
            OT_TIMER_IN <= !ot_s;                               // Pin still timed as input
            PIN6_O      <= p6_level;
            PIN6_OE     <= p6_drive;
            PIN6_IN     <= p6_drive ? 1'b0 : pin6_s;
            VID_CODE    <= vid_mode ? vid_s : '0;
            GPIO_IN     <= vid_mode ? '0 : vid_s;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_lock_holds: assert property (@(posedge CLK) disable iff (SRST)
        LOCK |=> $stable(cfg))
        else $error("register changed while locked");
    chk_write_lands: assert property (@(posedge CLK) disable iff (SRST)
        (REQ.wr && REQ.addr == TFOC_ADDR && !LOCK) |=> 8'(cfg) == $past(REQ.wdata))
        else $error("unlocked write not stored");
    chk_reset_value: assert property (@(posedge CLK)
        $past(SRST) |-> 8'(cfg) == TFOC_RESET)
        else $error("reset value wrong");
    chk_ot_gated: assert property (@(posedge CLK) disable iff (SRST)
        $past(ch_en, 2) == '0 && $past(ch_en) == '0 |-> !OT_OE)
        else $error("overtemp pin driven with all channels disabled");
    chk_p6_dir: assert property (@(posedge CLK) disable iff (SRST)
        ##1 PIN6_OE == $past(cfg.gp_pin6_direction))
        else $error("pin six direction mismatch");
    chk_p6_pol: assert property (@(posedge CLK) disable iff (SRST)
        ##1 PIN6_O == ($past(cfg.gp_pin6_polarity) ? $past(PIN6_VALUE) : !$past(PIN6_VALUE)))
        else $error("pin six level mismatch");
    chk_vid_route: assert property (@(posedge CLK) disable iff (SRST)
        ##1 ($past(cfg.voltage_id_pin_select) ? VID_CODE == '0 : GPIO_IN == '0))
        else $error("five-pin group routed to wrong function");
    chk_ot_low: assert property (@(posedge CLK) disable iff (SRST)
        OT_OE |-> !OT_O)
        else $error("overtemp pin driven high");
endmodule
`default_nettype wire

// ==== testbench/tfoc_top_tb.sv ====
// Self-checking testbench for the temperature format / overtemp configuration register
`timescale 1ns/100ps
`default_nettype none
module tfoc_top_tb;
    import tfoc_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic        CLK, SRST, LOCK, PIN6_I, PIN6_VALUE, OT_I;
    tfoc_req_t   REQ;
    logic [23:0] RAW_TEMP, RAW_OFFSET, RAW_LIMIT;
    logic [4:0]  VID_PINS_I, VID_CODE, GPIO_IN;
    logic [7:0]  RDATA;
    tfoc_cfg_t   CFG;
    logic [29:0] TEMP_HALF;
    logic        PIN6_O, PIN6_OE, PIN6_IN, OT_O, OT_OE, OT_TIMER_IN;
    int          n_errors;
    int          compares;

    tfoc_top i_dut (.CLK(CLK), .SRST(SRST), .REQ(REQ), .LOCK(LOCK), .RDATA(RDATA), .CFG(CFG),
        .RAW_TEMP(RAW_TEMP), .RAW_OFFSET(RAW_OFFSET), .RAW_LIMIT(RAW_LIMIT),
        .TEMP_HALF(TEMP_HALF), .PIN6_I(PIN6_I), .PIN6_VALUE(PIN6_VALUE), .PIN6_O(PIN6_O),
        .PIN6_OE(PIN6_OE), .PIN6_IN(PIN6_IN), .VID_PINS_I(VID_PINS_I), .VID_CODE(VID_CODE),
        .GPIO_IN(GPIO_IN), .OT_I(OT_I), .OT_O(OT_O), .OT_OE(OT_OE), .OT_TIMER_IN(OT_TIMER_IN));

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write pulse, then wait until the registered copy on CFG has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        REQ.wr = 1'b1;
        REQ.addr = a;
        REQ.wdata = d;
        @(negedge CLK);
        REQ.wr = 1'b0;
        @(negedge CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        REQ.rd = 1'b1;
        REQ.addr = a;
        @(negedge CLK);
        REQ.rd = 1'b0;
        check("RDATA", 10'(exp), 10'(RDATA));
        // Let an edge pass so a following read raises the strobe afresh
        @(negedge CLK);
    endtask

    // Pin inputs pass a two-stage synchroniser, channel math two stages
    task automatic settle();
        repeat (5) @(negedge CLK);
    endtask

    task automatic temps(input logic [9:0] exp);
        settle();
        for (int ch = 0; ch < NCHAN; ch++) begin
            check("TEMP_HALF", exp, TEMP_HALF[ch*10 +: 10]);
        end
    endtask

    task automatic ot(input logic [7:0] c, input int ch, input logic [7:0] lim, input logic e);
        RAW_LIMIT = {3{8'h7f}};
        RAW_LIMIT[ch*8 +: 8] = lim;
        wr(TFOC_ADDR, c);
        settle();
        check("OT_OE", 10'(e), 10'(OT_OE));
        check("OT_O", 10'h000, 10'(OT_O));
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // 50 MHz clock
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #100us;
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        compares = 0;
        SRST = 1'b1;
        LOCK = 1'b0;
        REQ = '0;
        PIN6_I = 1'b1;
        PIN6_VALUE = 1'b1;
        OT_I = 1'b1;
        VID_PINS_I = 5'h15;
        RAW_TEMP = {3{8'h32}};
        RAW_OFFSET = {3{8'h04}};
        RAW_LIMIT = {3{8'h7f}};
        repeat (20) @(negedge CLK);
        SRST = 1'b0;
        check("CFG", 10'(TFOC_RESET), 10'(CFG));
        rd(TFOC_ADDR, TFOC_RESET);
        rd(8'h7b, 8'h00);
        // Each field set alone, seen on CFG and read back
        for (int b = 0; b < 8; b++) begin
            wr(TFOC_ADDR, 8'h01 << b);
            check("CFG", 10'(8'h01 << b), 10'(CFG));
            rd(TFOC_ADDR, 8'h01 << b);
        end
        wr(TFOC_ADDR, 8'h01);
        LOCK = 1'b1;
        wr(TFOC_ADDR, 8'hfe);
        check("CFG", 10'h001, 10'(CFG));
        rd(TFOC_ADDR, 8'h01);
        LOCK = 1'b0;
        temps(10'd104);
        wr(TFOC_ADDR, 8'h03);
        temps(10'd108);
        RAW_TEMP = {3{8'h72}};
        wr(TFOC_ADDR, 8'h00);
        temps(10'd104);
        // Overtemp drive per channel in both formats, sentinel limits
        for (int ch = 0; ch < NCHAN; ch++) begin
            ot(8'h20 << ch, ch, 8'h68, 1'b1);
            ot(8'h00, ch, 8'h68, 1'b0);
            ot(8'h20 << ch, ch, LIM_OFF_OFS64, 1'b0);
            RAW_TEMP = {3{8'h32}};
            ot(8'h01 | (8'h20 << ch), ch, 8'h28, 1'b1);
            ot(8'h01 | (8'h20 << ch), ch, LIM_OFF_TWOS, 1'b0);
            RAW_TEMP = {3{8'h72}};
        end
        OT_I = 1'b0;
        settle();
        check("OT_TIMER_IN", 10'h001, 10'(OT_TIMER_IN));
        // Pin six direction and active level, then five-pin group routing
        wr(TFOC_ADDR, 8'h0c);
        settle();
        check("PIN6_OE", 10'h001, 10'(PIN6_OE));
        check("PIN6_O", 10'h001, 10'(PIN6_O));
        wr(TFOC_ADDR, 8'h04);
        settle();
        check("PIN6_O", 10'h000, 10'(PIN6_O));
        wr(TFOC_ADDR, 8'h00);
        settle();
        check("PIN6_OE", 10'h000, 10'(PIN6_OE));
        check("PIN6_IN", 10'h001, 10'(PIN6_IN));
        check("VID_CODE", 10'h015, 10'(VID_CODE));
        wr(TFOC_ADDR, 8'h10);
        settle();
        check("VID_CODE", 10'h000, 10'(VID_CODE));
        check("GPIO_IN", 10'h015, 10'(GPIO_IN));
        print_verdict();
    end
endmodule
`default_nettype wire
